// File: inc/gpe_pkg.sv
// Constants, register map and carrier types of the eight-pin port block.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
package gpe_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] GPE_IDX_DRIVE_EN       = 6'h00;
  localparam logic [5:0] GPE_IDX_DRIVE_EN_SET   = 6'h01;
  localparam logic [5:0] GPE_IDX_DRIVE_EN_CLR   = 6'h02;
  localparam logic [5:0] GPE_IDX_DRIVE_EN_TGL   = 6'h03;
  localparam logic [5:0] GPE_IDX_LEVEL          = 6'h04;
  localparam logic [5:0] GPE_IDX_LEVEL_SET      = 6'h05;
  localparam logic [5:0] GPE_IDX_LEVEL_CLR      = 6'h06;
  localparam logic [5:0] GPE_IDX_LEVEL_TGL      = 6'h07;
  localparam logic [5:0] GPE_IDX_PIN_CFG_BASE   = 6'h10;
  localparam logic [5:0] GPE_IDX_MULTI_PIN_MASK = 6'h18;
  localparam logic [5:0] GPE_IDX_CLK_EVT_OUT    = 6'h19;
  localparam logic [5:0] GPE_IDX_VPORT_MAP      = 6'h1A;
  localparam int         GPE_ADDR_LSB           = 2;

  // ****************************************************************
  // Field positions and encodings
  // ****************************************************************
  localparam int         GPE_CFG_INVERT_BIT = 6;
  localparam int         GPE_CFG_SENSE_LSB  = 0;
  localparam logic [2:0] GPE_SENSE_BOTH     = 3'h0;
  localparam logic [2:0] GPE_SENSE_RISING   = 3'h1;
  localparam logic [2:0] GPE_SENSE_FALLING  = 3'h2;
  localparam logic [2:0] GPE_SENSE_LEVEL    = 3'h3;
  localparam logic [7:0] GPE_CFG_WR_MASK    = 8'h7F;
  localparam int         GPE_CEO_CLK_BIT    = 0;
  localparam int         GPE_CEO_EVT_BIT    = 1;
  localparam int         GPE_CEO_PIN_LSB    = 2;
  localparam int         GPE_VP_EN_BIT      = 3;
  localparam logic [1:0] GPE_HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0] GPE_HTRANS_SEQ     = 2'h3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  GPE_RST_BYTE = 8'h00;
  localparam logic [31:0] GPE_RST_WORD = 32'h0000_0000;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] en;   // Peripheral takes the pin
    logic [7:0] oe;   // Peripheral drive enable
    logic [7:0] out;  // Peripheral pin value
  } gpe_ovr_t;

  typedef struct packed {
    logic       wr;    // One-cycle virtual write strobe
    logic [1:0] slot;  // Virtual slot number
    logic       sel;   // 0 drive enable, 1 level
    logic [7:0] data;  // Byte written
  } gpe_vwr_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpe_pad_t;

  typedef struct packed {
    logic [7:0]      dir;
    logic [7:0]      lvl;
    logic [7:0]      mask;
    logic [7:0][7:0] cfg;
    logic [4:0]      ceo;
    logic [3:0][3:0] vmap;
    logic [7:0]      sync1;
    logic [7:0]      sync2;
    logic [7:0]      prev;
    logic [7:0]      evs;
    logic [7:0]      evd;
    logic            evch;
    logic            wpend;
    logic [5:0]      widx;
    logic [31:0]     rdata;
  } gpe_state_t;

endpackage : gpe_pkg

// File: logic/gpe_port.sv
// Eight-pin general purpose port: drive enable and level registers with
// set/clear/toggle strobes, pin events, clock/event output, multi-pin
// configuration, virtual port writes and peripheral override.
// Assumes one AHB-Lite master, word transfers only, pads resolved outside.
//
// Overview of operation
// - Pin events are made only by clocked logic on the peripheral clock.
// - Edge events need the changed level sampled by the clock first.
// - Level sense: low gives nothing, high gives an event every clock.
// - Polarity inversion makes a low pin appear high for level sensing.
// - Signal event follows sense; data event always carries the pin level.
// - Enabled peripheral overrides replace pin drive; software cannot see them.
// - Peripheral clock or event channel 0 can drive a selectable pin.
// - A routed event stays on the pin for the event's whole duration.
// - One pin configuration write updates every pin chosen by the mask.
// - Mapped virtual port writes act like plain drive enable or level writes.
// - Four virtual port slots allow four ports mapped at once.
// - Drive enable bit one makes pin output, zero makes it input.
// - Writing one to drive enable set strobe sets that bit.
// - Writing one to drive enable clear strobe clears that bit.
// - Writing one to drive enable toggle strobe inverts that bit.
// - Drive enable strobe registers read back the drive enable value.
// - Level bit drives pin high or low only while pin is output.
// - Writing one to level set strobe sets that level bit.
// - Writing one to level clear strobe clears that level bit.
// - Writing one to level toggle strobe inverts that level bit.
// - Level strobe registers read back the level register value.
// - Polarity inversion inverts both driven data and read data.
// - Three-bit sense: 000 both edges, 001 rising, 010 falling.
module gpe_port
  import gpe_pkg::*;
#(
  parameter logic [2:0] PORT_ID = 3'h0  // This port's number for virtual mapping
)(
  input  wire logic              hclk,       // Peripheral clock
  input  wire logic              hresetn,    // Asynchronous reset, active low
  input  wire logic              hsel,       // Slave select
  input  wire logic [31:0]       haddr,      // Byte address
  input  wire logic [1:0]        htrans,     // Transfer type
  input  wire logic              hwrite,     // Write when high
  input  wire logic [2:0]        hsize,      // Transfer size
  input  wire logic [31:0]       hwdata,     // Write data
  input  wire logic              hready,     // Bus ready in
  output logic      [31:0]       hrdata,     // Read data
  output logic                   hreadyout,  // Always ready
  output logic                   hresp,      // Always OKAY
  input  wire gpe_pkg::gpe_vwr_t vport_wr,   // Virtual port write
  input  wire gpe_pkg::gpe_ovr_t periph_ovr, // Peripheral override
  input  wire logic              evch0,      // Event channel 0
  input  wire logic [7:0]        pad_in,     // Pin levels
  output gpe_pkg::gpe_pad_t      pad,        // Pin drive and enable
  output logic      [7:0]        pin_value,  // Synchronised pin value
  output logic      [7:0]        evt_signal, // Signal events
  output logic      [7:0]        evt_data    // Data events
);

  // ****************************************************************
  // State
  // ****************************************************************
  gpe_state_t st_reg;
  gpe_state_t st_next;

  logic [7:0] inv;
  logic [7:0] seen;
  logic [5:0] aidx;
  logic       acc_valid;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] read_mux(input gpe_state_t s, input logic [5:0] idx);
    logic [31:0] r;
    r = GPE_RST_WORD;
    unique case (idx)
      GPE_IDX_DRIVE_EN,
      GPE_IDX_DRIVE_EN_SET,
      GPE_IDX_DRIVE_EN_CLR,
      GPE_IDX_DRIVE_EN_TGL:   r[7:0] = s.dir;
      GPE_IDX_LEVEL,
      GPE_IDX_LEVEL_SET,
      GPE_IDX_LEVEL_CLR,
      GPE_IDX_LEVEL_TGL:      r[7:0] = s.lvl;
      GPE_IDX_MULTI_PIN_MASK: r[7:0] = s.mask;
      GPE_IDX_CLK_EVT_OUT:    r[4:0] = s.ceo;
      GPE_IDX_VPORT_MAP:      r[15:0] = s.vmap;
      default:
      begin
        if (idx[5:3] == GPE_IDX_PIN_CFG_BASE[5:3])
        begin
          r[7:0] = s.cfg[idx[2:0]];
        end
      end
    endcase
    return r;
  endfunction : read_mux

  function automatic logic [7:0] strobe(input logic [7:0] cur, input logic [1:0] op, input logic [7:0] d);
    logic [7:0] r;
    r = cur;
    unique case (op)
      2'h0: r = d;          // Plain write
      2'h1: r = cur | d;
      2'h2: r = cur & ~d;
      2'h3: r = cur ^ d;
    endcase
    return r;
  endfunction : strobe

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_next   = st_reg;
    aidx      = haddr[GPE_ADDR_LSB+5:GPE_ADDR_LSB];
    acc_valid = hsel && hready && (htrans == GPE_HTRANS_NONSEQ || htrans == GPE_HTRANS_SEQ);
    for (int i = 0; i < 8; i++)
    begin
      inv[i] = st_reg.cfg[i][GPE_CFG_INVERT_BIT];
    end

    // Write data phase
    if (st_reg.wpend)
    begin
      if (st_reg.widx[5:2] == GPE_IDX_DRIVE_EN[5:2])
      begin
        st_next.dir = strobe(st_reg.dir, st_reg.widx[1:0], hwdata[7:0]);
      end
      else if (st_reg.widx[5:2] == GPE_IDX_LEVEL[5:2])
      begin
        st_next.lvl = strobe(st_reg.lvl, st_reg.widx[1:0], hwdata[7:0]);
      end
      else if (st_reg.widx[5:3] == GPE_IDX_PIN_CFG_BASE[5:3])
      begin
        for (int i = 0; i < 8; i++)
        begin
          if (st_reg.mask[i] || (st_reg.mask == GPE_RST_BYTE && i == int'(st_reg.widx[2:0])))
          begin
            st_next.cfg[i] = hwdata[7:0] & GPE_CFG_WR_MASK;
          end
        end
      end
      else if (st_reg.widx == GPE_IDX_MULTI_PIN_MASK)
      begin
        st_next.mask = hwdata[7:0];
      end
      else if (st_reg.widx == GPE_IDX_CLK_EVT_OUT)
      begin
        st_next.ceo = hwdata[4:0];
      end
      else if (st_reg.widx == GPE_IDX_VPORT_MAP)
      begin
        st_next.vmap = hwdata[15:0];
      end
    end

    // Virtual port write lands on the real register
    if (vport_wr.wr && st_reg.vmap[vport_wr.slot][GPE_VP_EN_BIT]
        && st_reg.vmap[vport_wr.slot][2:0] == PORT_ID)
    begin
      if (vport_wr.sel)
      begin
        st_next.lvl = vport_wr.data;
      end
      else
      begin
        st_next.dir = vport_wr.data;
      end
    end

    // Address phase
    st_next.wpend = acc_valid && hwrite;
    st_next.widx  = aidx;
    if (acc_valid && !hwrite)
    begin
      st_next.rdata = read_mux(st_reg, aidx);
    end

    // Pin sampling and events on the clock only
    st_next.sync1 = pad_in;
    st_next.sync2 = st_reg.sync1;
    seen          = st_reg.sync2 ^ inv;
    st_next.prev  = seen;
    for (int i = 0; i < 8; i++)
    begin
      unique case (st_reg.cfg[i][GPE_CFG_SENSE_LSB +: 3])
        GPE_SENSE_BOTH:    st_next.evs[i] = seen[i] ^ st_reg.prev[i];
        GPE_SENSE_RISING:  st_next.evs[i] = seen[i] & ~st_reg.prev[i];
        GPE_SENSE_FALLING: st_next.evs[i] = ~seen[i] & st_reg.prev[i];
        GPE_SENSE_LEVEL:   st_next.evs[i] = seen[i];
        default:           st_next.evs[i] = 1'b0;
      endcase
    end
    st_next.evd  = seen;
    st_next.evch = evch0;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  always_comb
  begin
    pad.oe  = st_reg.dir;
    pad.out = st_reg.lvl ^ inv;
    if (st_reg.ceo[GPE_CEO_CLK_BIT])
    begin
      pad.oe[st_reg.ceo[GPE_CEO_PIN_LSB +: 3]]  = 1'b1;
      pad.out[st_reg.ceo[GPE_CEO_PIN_LSB +: 3]] = hclk;
    end
    else if (st_reg.ceo[GPE_CEO_EVT_BIT])
    begin
      pad.oe[st_reg.ceo[GPE_CEO_PIN_LSB +: 3]]  = 1'b1;
      pad.out[st_reg.ceo[GPE_CEO_PIN_LSB +: 3]] = st_reg.evch;
    end
    for (int i = 0; i < 8; i++)
    begin
      if (periph_ovr.en[i])
      begin
        pad.oe[i]  = periph_ovr.oe[i];
        pad.out[i] = periph_ovr.out[i];
      end
    end
  end

  assign pin_value  = st_reg.sync2 ^ inv;
  assign evt_signal = st_reg.evs;
  assign evt_data   = st_reg.evd;
  assign hrdata     = st_reg.rdata;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

endmodule : gpe_port

// File: tb/gpe_port_sva.sv
// Concurrent checks on the port block's bus, pad and event outputs.
// Bound to gpe_port from the bench top; sees only its ports.
module gpe_port_sva
  import gpe_pkg::*;
(
  input wire logic              hclk,       // Clock
  input wire logic              hresetn,    // Reset, active low
  input wire logic              hsel,       // Select
  input wire logic [31:0]       haddr,      // Address
  input wire logic [1:0]        htrans,     // Transfer type
  input wire logic              hwrite,     // Write
  input wire logic              hready,     // Ready in
  input wire logic [31:0]       hrdata,     // Read data
  input wire logic              hreadyout,  // Ready out
  input wire logic              hresp,      // Response
  input wire gpe_pkg::gpe_ovr_t periph_ovr, // Override
  input wire gpe_pkg::gpe_pad_t pad,        // Pad drive
  input wire logic [7:0]        pin_value,  // Pin value
  input wire logic [7:0]        evt_signal, // Signal events
  input wire logic [7:0]        evt_data    // Data events
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Checks
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd = hsel && hready && htrans[1] && !hwrite;
  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled or error");
  chk_rd_upper: assert property (hrdata[31:16] == 16'h0000) else $error("read data upper bits set");
  chk_unmapped_rd: assert property (rd && haddr[7:2] inside {[6'h08:6'h0F]} |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_cfg_bit7: assert property (rd && haddr[7:5] == 3'h2 |=> !hrdata[7]) else $error("config bit 7 set");
  chk_ovr_drive: assert property ((((pad.oe ^ periph_ovr.oe) | ((pad.out ^ periph_ovr.out) & periph_ovr.oe))
    & periph_ovr.en) == 8'h00) else $error("override not on pad");
  chk_data_evt: assert property (evt_data == $past(pin_value)) else $error("data event not pin value");
  chk_evt_cause: assert property ((evt_signal & ~evt_data & ~(evt_data ^ $past(evt_data))) == 8'h00)
    else $error("event without edge or level");
  chk_rst_quiet: assert property ($rose(hresetn) |-> evt_signal == 8'h00 && evt_data == 8'h00)
    else $error("event out of reset");
endmodule : gpe_port_sva

// File: tb/gpe_pin_model.sv
// Pin-side model: external circuitry on the eight port pins.
// Driven pins read back their drive; others follow the external drivers.
module gpe_pin_model
  import gpe_pkg::*;
(
  input wire gpe_pkg::gpe_pad_t pad,   // Port drive
  input wire logic [7:0]        ext,   // External drivers
  output logic     [7:0]        pad_in // Resolved levels
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pad_in = (pad.oe & pad.out) | (~pad.oe & ext);
endmodule : gpe_pin_model

// File: tb/gpio_port_direction_output_events_tb.sv
// Self-checking bench of the eight-pin port block.
// Assumes a single AHB-Lite slave that answers with zero wait states.
module gpio_port_direction_output_events_tb import gpe_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic              hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, evch0 = 0, hreadyout, hresp;
  logic [31:0]       haddr = 0, hwdata = 0, hrdata, rv;
  logic [1:0]        htrans = 0;
  logic [7:0]        ext = 0, pad_in, pin_value, evt_signal, evt_data, dir_m = 0, lvl_m = 0, d;
  logic [5:0]        k;
  gpe_vwr_t          vport_wr = '0;
  gpe_ovr_t          periph_ovr = '0;
  gpe_pad_t          pad;
  int                num_errors = 0, comparisons = 0, c;
  int                ecnt[5][3] = '{'{0, 1, 1}, '{0, 1, 0}, '{0, 0, 1}, '{0, 6, 2}, '{8, 2, 6}};
  logic [7:0]        ecfg[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h43};
  gpe_port gpe_port_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .vport_wr, .periph_ovr, .evch0, .pad_in, .pad,
    .pin_value, .evt_signal, .evt_data);
  gpe_pin_model gpe_pin_model_i (.pad, .ext, .pad_in);
  initial
  begin
    forever #5 hclk = ~hclk;
  end
  // ****
  // Helpers
  // ****
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(logic w, logic [5:0] idx, logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= GPE_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  function automatic logic [7:0] nv(logic [1:0] op, logic [7:0] cur, logic [7:0] v);
    case (op)
      2'h0: return v;
      2'h1: return cur | v;
      2'h2: return cur & ~v;
      default: return cur ^ v;
    endcase
  endfunction : nv
  task automatic finish_test();
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    finish_test();
  end
  // ****
  // Tests
  // ****
  initial
  begin
    void'($urandom(32'h6fb4));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, 6'(i), 0, rv);
      chk("reset value", 0, rv);
    end
    for (int n = 0; n < 60; n++)
    begin
      k = 6'($urandom % 8);
      d = 8'($urandom);
      bus(1'b1, k, {24'h0, d}, rv);
      if (k < 4) dir_m = nv(k[1:0], dir_m, d);
      else lvl_m = nv(k[1:0], lvl_m, d);
      k = 6'($urandom % 8);
      bus(1'b0, k, 0, rv);
      chk("readback", (k < 4) ? dir_m : lvl_m, rv);
      #1 chk("pad drive", {dir_m, lvl_m & dir_m}, {pad.oe, pad.out & dir_m});
    end
    bus(1'b0, 6'h08, 0, rv);
    chk("unmapped", 0, rv);
    bus(1'b1, GPE_IDX_DRIVE_EN, 0, rv);
    dir_m = 0;
    for (int t = 0; t < 5; t++)
    begin
      bus(1'b1, GPE_IDX_PIN_CFG_BASE, {24'h0, ecfg[t]}, rv);
      repeat (6) @(posedge hclk);
      for (int p = 0; p < 3; p++)
      begin
        @(posedge hclk);
        ext <= {7'h0, p == 1};
        c = 0;
        repeat (8)
        begin
          @(posedge hclk);
          #1 c += evt_signal[0];
        end
        chk("event count", ecnt[t][p], c);
      end
    end
    bus(1'b1, GPE_IDX_DRIVE_EN_SET, 1, rv);
    bus(1'b1, GPE_IDX_LEVEL_CLR, 32'h21, rv);
    dir_m = 1;
    lvl_m = lvl_m & 8'hDE;
    #1 chk("inverted drive", 1, pad.out[0]);
    repeat (3) @(posedge hclk);
    #1 chk("inverted read", 0, pin_value[0]);
    bus(1'b1, GPE_IDX_MULTI_PIN_MASK, 32'h0C, rv);
    bus(1'b1, GPE_IDX_PIN_CFG_BASE + 6'h1, 32'h29, rv);
    for (int i = 1; i < 4; i++)
    begin
      bus(1'b0, GPE_IDX_PIN_CFG_BASE + 6'(i), 0, rv);
      chk("multi pin", (i > 1) ? 32'h29 : 32'h0, rv);
    end
    bus(1'b1, GPE_IDX_MULTI_PIN_MASK, 0, rv);
    bus(1'b1, GPE_IDX_CLK_EVT_OUT, 32'h16, rv);
    @(posedge hclk);
    evch0 <= 1'b1;
    @(posedge hclk);
    evch0 <= 1'b0;
    #1 chk("event out", 2'h3, {pad.oe[5], pad.out[5]});
    @(posedge hclk);
    #1 chk("event end", 0, pad.out[5]);
    bus(1'b1, GPE_IDX_CLK_EVT_OUT, 32'h15, rv);
    @(posedge hclk);
    #2 chk("clock out high", 1, pad.out[5]);
    #5 chk("clock out low", 0, pad.out[5]);
    bus(1'b1, GPE_IDX_CLK_EVT_OUT, 0, rv);
    @(posedge hclk);
    periph_ovr <= {8'h80, 8'h80, 8'h80};
    @(posedge hclk);
    #1 chk("override", 2'h3, {pad.oe[7], pad.out[7]});
    bus(1'b0, GPE_IDX_DRIVE_EN, 0, rv);
    chk("override hidden", dir_m, rv);
    periph_ovr <= '0;
    for (int s = 0; s < 4; s++)
    begin
      bus(1'b1, GPE_IDX_VPORT_MAP, 32'h8 << (4 * s), rv);
      d = 8'($urandom);
      @(posedge hclk);
      vport_wr <= {1'b1, 2'(s), 1'b1, d};
      @(posedge hclk);
      vport_wr <= '0;
      bus(1'b0, GPE_IDX_LEVEL, 0, rv);
      chk("virtual write", d, rv);
    end
    @(posedge hclk);
    vport_wr <= {1'b1, 2'h0, 1'b0, 8'hFF};
    @(posedge hclk);
    vport_wr <= '0;
    bus(1'b0, GPE_IDX_DRIVE_EN, 0, rv);
    chk("unmapped slot", dir_m, rv);
    bus(1'b1, GPE_IDX_VPORT_MAP, 32'h8, rv);
    @(posedge hclk);
    vport_wr <= {1'b1, 2'h0, 1'b0, 8'h5A};
    @(posedge hclk);
    vport_wr <= '0;
    bus(1'b0, GPE_IDX_DRIVE_EN, 0, rv);
    chk("virtual drive", 32'h5A, rv);
    finish_test();
  end
endmodule : gpio_port_direction_output_events_tb
bind gpe_port gpe_port_sva gpe_port_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .periph_ovr, .pad, .pin_value, .evt_signal, .evt_data);
